// *** core/usb_endpoint_ctrl_status.sv ***
/*
  Per-endpoint control and status flags, type, toggle, enable and
  received byte count, plus the per-endpoint reset register.
  Assumes a usb protocol engine on the same clock that reports one
  event per cycle on EVT_IN and obeys the stall, refuse and toggle
  outputs; firmware drives the plain register port.
*/
`timescale 1ns/1ns

// Overview of operation
// - endpoint reset clears fifo, count, toggle
// - reset bit held: pointers zero, count reads zero
// - reset is set then clear; flags kept
// - host ack of in sets tx complete
// - interrupt while any flag reads one
// - bank 0 flag set on store, firmware clears
// - byte count of active bank reported
// - setup flag set on setup, firmware clears
// - out data refused while setup flag set
// - stall acked flag on non-iso endpoints
// - iso endpoints report crc error on bit 3
// - tx ready held until in token, then cleared
// - force stall bit written and read back
// - control stall ends the pending request
// - bulk and interrupt stall means halted
// - bank 1 flag for ping-pong endpoints
// - endpoint type resets to control
module usb_endpoint_ctrl_status
  import ep_ctrl_pkg::*;
#(
  parameter int NUM_EP = `EP_COUNT
) (
  input wire logic REF_CLK_IN, // 100 MHz clock
  input wire logic RST_N_IN, // async reset, active low
  input wire logic [`ADDR_W-1:0] ADDR_IN, // register byte address
  input wire logic [31:0] WDATA_IN, // write data
  input wire logic WR_IN, // write strobe
  input wire logic RD_IN, // read strobe
  output logic [31:0] RDATA_OUT, // read data, cycle after strobe
  input wire usb_evt_t EVT_IN, // protocol engine event
  output logic [NUM_EP-1:0] TX_READY_OUT, // payload waiting for in token
  output logic [NUM_EP-1:0] STALL_OUT, // answer host with stall
  output logic [NUM_EP-1:0] OUT_REFUSE_OUT, // refuse out data
  output logic [NUM_EP-1:0] TOGGLE_OUT, // expected data pid, 1 = data1
  output logic [NUM_EP-1:0] FIFO_CLEAR_OUT, // hold fifo pointers at zero
  output logic [NUM_EP-1:0] EP_ENABLE_OUT, // endpoint enabled
  output logic [NUM_EP-1:0] DIR_OUT, // control data stage is in
  output logic [NUM_EP-1:0] EP_IRQ_OUT // endpoint interrupt level
);

  initial begin
    if (NUM_EP != `EP_COUNT) begin
      $error("NUM_EP must equal the endpoint count of the state layout");
    end
  end

  st_t q;
  st_t d;

  function automatic logic is_iso(input logic [2:0] ep_type);
    is_iso = (ep_type[1:0] == `TYPE_ISO_LOW);
  endfunction

  function automatic logic is_control(input logic [2:0] ep_type);
    is_control = (ep_type == `TYPE_CONTROL);
  endfunction

  // csr index of an address, or NUM_EP when it is no csr
  function automatic logic [2:0] csr_index(input logic [`ADDR_W-1:0] addr);
    logic [`ADDR_W-1:0] ofs;
    ofs = addr - `OFS_CSR_BASE;
    csr_index = 3'(NUM_EP);
    if (addr >= `OFS_CSR_BASE && ofs[1:0] == 2'h0 &&
        ofs[`ADDR_W-1:2] < (`ADDR_W-2)'(NUM_EP)) begin
      csr_index = ofs[4:2];
    end
  endfunction

  function automatic logic [31:0] csr_word(input ep_t e, input logic rst);
    logic [31:0] w;
    w = `CSR_RESET;
    w[`BIT_TX_COMPLETE] = e.tx_complete_flag;
    w[`BIT_RX_BANK0] = e.rx_bank0_full;
    w[`BIT_SETUP] = e.setup_received_flag;
    w[`BIT_STALL_ISO] = e.stall_iso_flag;
    w[`BIT_TX_READY] = e.tx_payload_ready;
    w[`BIT_FORCE_STALL] = e.force_stall_bit;
    w[`BIT_RX_BANK1] = e.rx_bank1_full;
    w[`BIT_DIR] = e.dir;
    w[`BIT_TYPE_HI:`BIT_TYPE_LO] = e.endpoint_type_field;
    w[`BIT_TOGGLE] = e.data_toggle_state;
    w[`BIT_ENABLE] = e.endpoint_enable_bit | is_control(e.endpoint_type_field);
    if (!rst) begin
      w[`BIT_COUNT_HI:`BIT_COUNT_LO] = e.rx_byte_count;
    end
    csr_word = w;
  endfunction

  function automatic logic any_flag(input ep_t e);
    any_flag = e.tx_complete_flag | e.rx_bank0_full | e.setup_received_flag |
               e.stall_iso_flag | e.rx_bank1_full;
  endfunction

  always_comb begin
    logic [2:0] widx;
    logic [2:0] ridx;
    logic hit;
    hit = 1'b0;
    d = q;
    widx = csr_index(ADDR_IN);
    ridx = csr_index(ADDR_IN);
    d.rdata = 32'h0000_0000;

    // register reads, answered in the next cycle
    if (RD_IN) begin
      if (ADDR_IN == `OFS_RST_EP) begin
        d.rdata[NUM_EP-1:0] = q.reset_endpoint_bit;
      end else if (ridx < 3'(NUM_EP)) begin
        d.rdata = csr_word(q.ep[ridx], q.reset_endpoint_bit[ridx]);
      end
    end

    // endpoint reset register is a plain level per endpoint
    if (WR_IN && ADDR_IN == `OFS_RST_EP) begin
      d.reset_endpoint_bit = WDATA_IN[NUM_EP-1:0];
    end

    for (int i = 0; i < NUM_EP; i++) begin
      // firmware write: flags clear on 0, keep on 1
      if (WR_IN && widx == 3'(i)) begin
        d.ep[i].tx_complete_flag = q.ep[i].tx_complete_flag &
                                   WDATA_IN[`BIT_TX_COMPLETE];
        d.ep[i].rx_bank0_full = q.ep[i].rx_bank0_full &
                                WDATA_IN[`BIT_RX_BANK0];
        d.ep[i].setup_received_flag = q.ep[i].setup_received_flag &
                                      WDATA_IN[`BIT_SETUP];
        d.ep[i].stall_iso_flag = q.ep[i].stall_iso_flag &
                                 WDATA_IN[`BIT_STALL_ISO];
        d.ep[i].rx_bank1_full = q.ep[i].rx_bank1_full &
                                WDATA_IN[`BIT_RX_BANK1];
        // writing 0 to tx ready has no effect; only the device clears it
        d.ep[i].tx_payload_ready = q.ep[i].tx_payload_ready |
                                   WDATA_IN[`BIT_TX_READY];
        d.ep[i].force_stall_bit = WDATA_IN[`BIT_FORCE_STALL];
        d.ep[i].dir = WDATA_IN[`BIT_DIR];
        d.ep[i].endpoint_type_field = WDATA_IN[`BIT_TYPE_HI:`BIT_TYPE_LO];
        if (!is_control(q.ep[i].endpoint_type_field)) begin
          d.ep[i].endpoint_enable_bit = WDATA_IN[`BIT_ENABLE];
        end
      end

      // protocol engine events; a set wins over a firmware clear in the same cycle
      hit = (EVT_IN.ep == 3'(i)) && q.enabled[i];
      if (hit) begin
        unique case (EVT_IN.kind)
          EV_NONE: begin
          end
          EV_IN_TOKEN: begin
            if (!(WR_IN && widx == 3'(i) && WDATA_IN[`BIT_TX_READY])) begin
              d.ep[i].tx_payload_ready = 1'b0;
            end
          end
          EV_IN_ACK: begin
            d.ep[i].tx_complete_flag = 1'b1;
            d.ep[i].data_toggle_state = ~q.ep[i].data_toggle_state;
          end
          EV_OUT_BANK0: begin
            if (!q.ep[i].setup_received_flag) begin
              d.ep[i].rx_bank0_full = 1'b1;
              d.ep[i].rx_byte_count = EVT_IN.count;
              d.ep[i].data_toggle_state = ~q.ep[i].data_toggle_state;
            end
          end
          EV_OUT_BANK1: begin
            if (!q.ep[i].setup_received_flag) begin
              d.ep[i].rx_bank1_full = 1'b1;
              d.ep[i].rx_byte_count = EVT_IN.count;
              d.ep[i].data_toggle_state = ~q.ep[i].data_toggle_state;
            end
          end
          EV_SETUP: begin
            d.ep[i].setup_received_flag = 1'b1;
            d.ep[i].rx_byte_count = EVT_IN.count;
            d.ep[i].data_toggle_state = 1'b1;
          end
          EV_STALL_ACK: begin
            if (!is_iso(q.ep[i].endpoint_type_field)) begin
              d.ep[i].stall_iso_flag = 1'b1;
            end
          end
          EV_ISO_CRC: begin
            if (is_iso(q.ep[i].endpoint_type_field)) begin
              d.ep[i].stall_iso_flag = 1'b1;
            end
          end
        endcase
      end

      // endpoint reset: count and toggle back to zero, flags untouched
      if (q.reset_endpoint_bit[i]) begin
        d.ep[i].rx_byte_count = '0;
        d.ep[i].data_toggle_state = 1'b0;
      end

      d.irq[i] = any_flag(d.ep[i]);
      d.enabled[i] = d.ep[i].endpoint_enable_bit |
                     is_control(d.ep[i].endpoint_type_field);
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      q <= '0; // all types control
      q.reset_endpoint_bit <= `RST_EP_RESET;
      q.enabled <= '1;
    end else begin
      q <= d;
    end
  end

  assign RDATA_OUT = q.rdata;
  assign EP_IRQ_OUT = q.irq;
  assign EP_ENABLE_OUT = q.enabled;
  assign FIFO_CLEAR_OUT = q.reset_endpoint_bit;

  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      TX_READY_OUT[i] = q.ep[i].tx_payload_ready;
      STALL_OUT[i] = q.ep[i].force_stall_bit;
      OUT_REFUSE_OUT[i] = q.ep[i].setup_received_flag;
      TOGGLE_OUT[i] = q.ep[i].data_toggle_state;
      DIR_OUT[i] = q.ep[i].dir;
    end
  end

endmodule

// *** shared/ep_ctrl_params.svh ***
/*
  Offsets, field positions, reset values and sizes of the endpoint
  control and status block.
  Assumes a byte-addressed register port with 8 address bits.
*/
`ifndef EP_CTRL_PARAMS_SVH
`define EP_CTRL_PARAMS_SVH

`define EP_COUNT 6
`define BYTE_CNT_W 11
`define ADDR_W 8

`define OFS_RST_EP 8'h28
`define OFS_CSR_BASE 8'h30
`define OFS_CSR_STEP 8'h04

`define BIT_TX_COMPLETE 0
`define BIT_RX_BANK0 1
`define BIT_SETUP 2
`define BIT_STALL_ISO 3
`define BIT_TX_READY 4
`define BIT_FORCE_STALL 5
`define BIT_RX_BANK1 6
`define BIT_DIR 7
`define BIT_TYPE_LO 8
`define BIT_TYPE_HI 10
`define BIT_TOGGLE 11
`define BIT_ENABLE 15
`define BIT_COUNT_LO 16
`define BIT_COUNT_HI 26

`define TYPE_CONTROL 3'h0
`define TYPE_ISO_LOW 2'h1
`define RST_EP_RESET 6'h00
`define CSR_RESET 32'h0000_0000

`endif

// *** shared/ep_ctrl_pkg.sv ***
/*
  Types of the endpoint control and status block.
  Assumes ep_ctrl_params.svh is on the include path.
*/
`include "ep_ctrl_params.svh"

package ep_ctrl_pkg;

  // one-hot event codes from the usb protocol engine
  typedef enum logic [6:0] {
    EV_NONE      = 7'b000_0000,
    EV_IN_TOKEN  = 7'b000_0001,
    EV_IN_ACK    = 7'b000_0010,
    EV_OUT_BANK0 = 7'b000_0100,
    EV_OUT_BANK1 = 7'b000_1000,
    EV_SETUP     = 7'b001_0000,
    EV_STALL_ACK = 7'b010_0000,
    EV_ISO_CRC   = 7'b100_0000
  } ev_kind_t;

  typedef struct packed {
    ev_kind_t kind;
    logic [2:0] ep;
    logic [`BYTE_CNT_W-1:0] count;
  } usb_evt_t;

  typedef struct packed {
    logic tx_complete_flag;
    logic rx_bank0_full;
    logic setup_received_flag;
    logic stall_iso_flag;
    logic tx_payload_ready;
    logic force_stall_bit;
    logic rx_bank1_full;
    logic dir;
    logic [2:0] endpoint_type_field;
    logic data_toggle_state;
    logic endpoint_enable_bit;
    logic [`BYTE_CNT_W-1:0] rx_byte_count;
  } ep_t;

  typedef struct packed {
    ep_t [`EP_COUNT-1:0] ep;
    logic [`EP_COUNT-1:0] reset_endpoint_bit;
    logic [`EP_COUNT-1:0] irq;
    logic [`EP_COUNT-1:0] enabled;
    logic [31:0] rdata;
  } st_t;

endpackage

// *** bench/usb_ep_monitor.sv ***
/* Concurrent checks on endpoint 0 and 1 behaviour at the block ports.
   Assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ns
`include "ep_ctrl_params.svh"
module usb_ep_monitor
  import ep_ctrl_pkg::*;
#(parameter int NUM_EP = `EP_COUNT) (
  input wire logic REF_CLK_IN, // clock
  input wire logic RST_N_IN, // reset
  input wire logic [`ADDR_W-1:0] ADDR_IN, // address
  input wire logic [31:0] WDATA_IN, // write data
  input wire logic WR_IN, // write
  input wire logic RD_IN, // read
  input wire logic [31:0] RDATA_OUT, // read data
  input wire usb_evt_t EVT_IN, // event
  input wire logic [NUM_EP-1:0] TX_READY_OUT, // tx ready
  input wire logic [NUM_EP-1:0] STALL_OUT, // stall
  input wire logic [NUM_EP-1:0] OUT_REFUSE_OUT, // refuse
  input wire logic [NUM_EP-1:0] TOGGLE_OUT, // toggle
  input wire logic [NUM_EP-1:0] FIFO_CLEAR_OUT, // fifo clear
  input wire logic [NUM_EP-1:0] EP_ENABLE_OUT, // enable
  input wire logic [NUM_EP-1:0] EP_IRQ_OUT // irq
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic wr0;
  logic ev0;
  assign wr0 = WR_IN && ADDR_IN == 8'h30;
  assign ev0 = EVT_IN.ep == 3'h0 && EP_ENABLE_OUT[0];
  rd_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0000_0000)
    else $error("read data outside read slot");
  in_ack_a: assert property (ev0 && EVT_IN.kind == EV_IN_ACK |=> EP_IRQ_OUT[0])
    else $error("in ack did not raise irq");
  setup_refuse_a: assert property (ev0 && EVT_IN.kind == EV_SETUP
    |=> OUT_REFUSE_OUT[0] && TOGGLE_OUT[0]) else $error("setup not flagged");
  irq_hold_a: assert property (EP_IRQ_OUT[0] && !wr0 |=> EP_IRQ_OUT[0])
    else $error("irq dropped");
  tx_token_a: assert property (TX_READY_OUT[0] && ev0 && EVT_IN.kind == EV_IN_TOKEN
    && !(wr0 && WDATA_IN[4]) |=> !TX_READY_OUT[0]) else $error("tx ready kept");
  tx_hold_a: assert property (TX_READY_OUT[0] && EVT_IN.kind != EV_IN_TOKEN
    |=> TX_READY_OUT[0]) else $error("tx ready lost");
  stall_wr_a: assert property (wr0 |=> STALL_OUT[0] == $past(WDATA_IN[5]))
    else $error("force stall mismatch");
  rst_wr_a: assert property (WR_IN && ADDR_IN == 8'h28
    |=> FIFO_CLEAR_OUT == $past(WDATA_IN[5:0])) else $error("ep reset mismatch");
  toggle_rst_a: assert property ((FIFO_CLEAR_OUT & $past(FIFO_CLEAR_OUT) & TOGGLE_OUT) == '0)
    else $error("toggle not cleared");
  cover property (ev0 && EVT_IN.kind == EV_SETUP);
  cover property (FIFO_CLEAR_OUT[1]);
  cover property (TX_READY_OUT[0] && EVT_IN.kind == EV_IN_TOKEN);
endmodule
bind usb_endpoint_ctrl_status usb_ep_monitor #(.NUM_EP(NUM_EP)) i_mon (
  .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .EVT_IN(EVT_IN),
  .TX_READY_OUT(TX_READY_OUT), .STALL_OUT(STALL_OUT), .OUT_REFUSE_OUT(OUT_REFUSE_OUT),
  .TOGGLE_OUT(TOGGLE_OUT), .FIFO_CLEAR_OUT(FIFO_CLEAR_OUT),
  .EP_ENABLE_OUT(EP_ENABLE_OUT), .EP_IRQ_OUT(EP_IRQ_OUT));

// *** bench/usb_host_model.sv ***
/* Behavioural usb host side: one engine event per call.
   Assumes it shares the block clock. */
`timescale 1ns/1ns
`include "ep_ctrl_params.svh"
module usb_host_model
  import ep_ctrl_pkg::*;
(
  input wire logic clk_in, // block clock
  output usb_evt_t evt_out // event to the block
);
  initial evt_out = '{kind: EV_NONE, ep: 3'h0, count: '0};
  // idle count is inverted so a stale value is never mistaken
  task automatic send(input ev_kind_t k, input logic [2:0] e,
                      input logic [`BYTE_CNT_W-1:0] n, input int gap);
    @(posedge clk_in);
    evt_out <= '{kind: k, ep: e, count: n};
    @(posedge clk_in);
    evt_out <= '{kind: EV_NONE, ep: 3'h0, count: ~n};
    repeat (gap) @(posedge clk_in);
  endtask
endmodule

// *** bench/tb_usb_endpoint_ctrl_status.sv ***
/* Self-checking bench for the endpoint control block.
   Assumes the host model drives events and firmware the register port. */
`timescale 1ns/1ns
`include "ep_ctrl_params.svh"
module tb_usb_endpoint_ctrl_status
  import ep_ctrl_pkg::*;
;
  logic clk, rst_n, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  usb_evt_t evt;
  logic [5:0] txr, stl, refu, tgl, fclr, ena, dir, irq;
  int err_count = 0;
  int total_checks = 0;
  usb_host_model i_host (.clk_in(clk), .evt_out(evt));
  usb_endpoint_ctrl_status i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .EVT_IN(evt),
    .TX_READY_OUT(txr), .STALL_OUT(stl), .OUT_REFUSE_OUT(refu), .TOGGLE_OUT(tgl),
    .FIFO_CLEAR_OUT(fclr), .EP_ENABLE_OUT(ena), .DIR_OUT(dir), .EP_IRQ_OUT(irq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a read always follows a write by a full cycle, so no polling is needed
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 0;
    // let the write settle before any port is looked at
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task automatic csr(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, d);
    check(d, exp);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rd_reg(8'h30 + 8'(4 * i), d);
      check(d & 32'hFFFF_7FFF, `CSR_RESET);
    end
    csr(8'h00, 32'h0000_0000);
    check({2'b00, ena, txr, stl, refu, tgl}, 32'h3F00_0000);
    check({14'h0, fclr, dir, irq}, 32'h0000_0000);
  endtask
  task automatic t_setup();
    i_host.send(EV_SETUP, 3'h0, 11'h008, 0);
    csr(8'h30, 32'h0008_8804);
    i_host.send(EV_OUT_BANK0, 3'h0, 11'h005, 2);
    csr(8'h30, 32'h0008_8804);
    wr_reg(8'h30, 32'h0000_0000);
    csr(8'h30, 32'h0008_8800);
    check({26'h0, irq}, 32'h0000_0000);
  endtask
  task automatic t_bank0();
    i_host.send(EV_OUT_BANK0, 3'h0, 11'h003, 0);
    csr(8'h30, 32'h0003_8002);
    wr_reg(8'h30, 32'h0000_0002);
    csr(8'h30, 32'h0003_8002);
    wr_reg(8'h30, 32'h0000_0000);
    csr(8'h30, 32'h0003_8000);
  endtask
  task automatic t_tx();
    check({26'h0, txr}, 32'h0000_0000);
    wr_reg(8'h30, 32'h0000_0010);
    wr_reg(8'h30, 32'h0000_0000);
    check({26'h0, txr}, 32'h0000_0001);
    i_host.send(EV_IN_TOKEN, 3'h0, 11'h000, 3);
    check({26'h0, txr}, 32'h0000_0000);
    i_host.send(EV_IN_ACK, 3'h0, 11'h000, 0);
    csr(8'h30, 32'h0003_8801);
    check({26'h0, irq}, 32'h0000_0001);
    wr_reg(8'h30, 32'h0000_0000);
    csr(8'h30, 32'h0003_8800);
  endtask
  task automatic t_stall();
    wr_reg(8'h30, 32'h0000_0020);
    csr(8'h30, 32'h0003_8820);
    check({26'h0, stl}, 32'h0000_0001);
    i_host.send(EV_STALL_ACK, 3'h0, 11'h000, 0);
    csr(8'h30, 32'h0003_8828);
    wr_reg(8'h30, 32'h0000_0000);
    csr(8'h30, 32'h0003_8800);
  endtask
  task automatic t_iso_rst();
    wr_reg(8'h34, 32'h0000_0100);
    wr_reg(8'h34, 32'h0000_8100);
    i_host.send(EV_ISO_CRC, 3'h1, 11'h000, 0);
    i_host.send(EV_OUT_BANK1, 3'h1, 11'h007, 0);
    csr(8'h34, 32'h0007_8948);
    wr_reg(8'h28, 32'h0000_0002);
    check({26'h0, fclr}, 32'h0000_0002);
    csr(8'h34, 32'h0000_8148);
    csr(8'h28, 32'h0000_0002);
    wr_reg(8'h28, 32'h0000_0000);
    csr(8'h34, 32'h0000_8148);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  initial begin
    rst_n = 0; wr = 0; rd = 0; addr = 8'h00; wdata = 32'h0000_0000;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_setup();
    t_bank0();
    t_tx();
    t_stall();
    t_iso_rst();
    end_of_test();
  end
endmodule
